// file: design/srfu_unit.sv
// Shift, rotate and status flag datapath slice of an 8-bit core
`timescale 1ns/100ps
module srfu_unit
  import srfu_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic op_valid,
  input wire srfu_pkg::srfu_op_type op_code,
  input wire logic [7:0] reg_in,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] status_flags_in,
  input wire logic status_load,
  output logic [7:0] result_r,
  output logic result_we_r,
  output logic [7:0] status_flags,
  output logic sleep_req_r,
  output logic watchdog_restart_r,
  output logic debug_break_r
);
  import srfu_pkg::*;

  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] result_nxt;
  logic write_reg_nxt;
  logic [7:0] status_eff;
  logic carry_in;
  logic transfer_in;
  logic dec_lshift;
  logic dec_rotl;
  logic dec_rotr;
  logic dec_ashift;
  logic dec_swap;
  logic dec_tstore;
  logic dec_tload;
  logic dec_sleep;
  logic dec_wdog;
  logic dec_break;
  logic is_shift;
  logic [7:0] lshift_val;
  logic [7:0] rotl_val;
  logic [7:0] rotr_val;
  logic [7:0] ashift_val;
  logic [7:0] shifted;
  logic shift_carry;
  logic shift_zero;
  logic new_n;
  logic new_v;
  logic new_s;
  logic [7:0] bit_mask;
  logic [7:0] swapped;
  logic [7:0] bit_loaded;
  logic [7:0] set_sel;
  logic [7:0] clr_sel;
  logic [7:0] idx_set;
  logic [7:0] idx_clr;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  // Status as an op sees it: a parallel load lands first
  assign status_eff = status_load ? status_flags_in : status_r;

  // Carry and transfer flag feed the datapath from the loaded view
  assign carry_in = status_eff[FLAG_C];
  assign transfer_in = status_eff[FLAG_T];

  // Shift decode; nothing is selected while op_valid is low
  assign dec_lshift = op_valid && (op_code == logical_shift_right_op);
  assign dec_rotl = op_valid && (op_code == rotate_left_carry_op);
  assign dec_rotr = op_valid && (op_code == rotate_right_carry_op);
  assign dec_ashift = op_valid && (op_code == arith_shift_right_op);
  assign is_shift = dec_lshift || dec_rotl || dec_rotr || dec_ashift;

  // Data operation decode
  assign dec_swap = op_valid && (op_code == nibble_swap_op);
  assign dec_tstore = op_valid && (op_code == bit_to_transfer_op);
  assign dec_tload = op_valid && (op_code == transfer_to_bit_op);

  // Control operation decode
  assign dec_sleep = op_valid && (op_code == sleep_op);
  assign dec_wdog = op_valid && (op_code == watchdog_restart_op);
  assign dec_break = op_valid && (op_code == debug_break_op);

  // Candidate shift results, all built every cycle
  assign lshift_val = {1'b0, reg_in[7:1]};
  assign rotl_val = {reg_in[6:0], carry_in};
  assign rotr_val = {carry_in, reg_in[7:1]};
  assign ashift_val = {reg_in[7], reg_in[7:1]};

  // Shifter selection; only the left rotate takes its carry from bit 7
  assign shifted = dec_lshift ? lshift_val :
    dec_rotl ? rotl_val :
    dec_rotr ? rotr_val :
    ashift_val;
  assign shift_carry = dec_rotl ? reg_in[7] : reg_in[0];
  assign shift_zero = (shifted == 8'h00);

  // Shift flags: V is N xor C, so S = N xor V reduces to C
  assign new_n = shifted[7];
  assign new_v = new_n ^ shift_carry;
  assign new_s = new_n ^ new_v;

  // Swap and bit load results; flags are left alone
  assign bit_mask = 8'h01 << bit_sel;
  assign swapped = {reg_in[3:0], reg_in[7:4]};
  assign bit_loaded = (reg_in & ~bit_mask) | (transfer_in ? bit_mask : 8'h00);

  // Dedicated set operations, one flag each
  assign set_sel[FLAG_C] = (op_code == carry_set_op);
  assign set_sel[FLAG_Z] = (op_code == zero_flag_set_op);
  assign set_sel[FLAG_N] = (op_code == negative_set_op);
  assign set_sel[FLAG_V] = (op_code == overflow_set_op);
  assign set_sel[FLAG_S] = (op_code == signed_flag_set_op);
  assign set_sel[FLAG_H] = (op_code == half_carry_set_op);
  assign set_sel[FLAG_T] = (op_code == transfer_flag_set_op);
  assign set_sel[FLAG_I] = (op_code == irq_global_enable_op);

  // Dedicated clear operations, one flag each
  assign clr_sel[FLAG_C] = (op_code == carry_clear_op);
  assign clr_sel[FLAG_Z] = (op_code == zero_flag_clear_op);
  assign clr_sel[FLAG_N] = (op_code == negative_clear_op);
  assign clr_sel[FLAG_V] = (op_code == overflow_clear_op);
  assign clr_sel[FLAG_S] = (op_code == signed_flag_clear_op);
  assign clr_sel[FLAG_H] = (op_code == half_carry_clear_op);
  assign clr_sel[FLAG_T] = (op_code == transfer_flag_clear_op);
  assign clr_sel[FLAG_I] = (op_code == irq_global_disable_op);

  // Indexed forms reuse the bit select
  assign idx_set = (op_code == status_bit_set_op) ? bit_mask : 8'h00;
  assign idx_clr = (op_code == status_bit_clear_op) ? bit_mask : 8'h00;

  // Final masks; dedicated and indexed selects never overlap
  assign flag_set = op_valid ?
    (set_sel | idx_set) : 8'h00;
  assign flag_clr = op_valid ?
    (clr_sel | idx_clr) : 8'h00;

  // Next result and status
  always_comb begin
    status_nxt = status_eff;
    result_nxt = reg_in;
    write_reg_nxt = 1'b0;
    if (is_shift) begin
      result_nxt = shifted;
      write_reg_nxt = 1'b1;
      status_nxt[FLAG_Z] = shift_zero;
      status_nxt[FLAG_C] = shift_carry;
      status_nxt[FLAG_N] = new_n;
      status_nxt[FLAG_V] = new_v;
      // S follows N xor V; only shifts derive it, the other ops set or clear it directly
      status_nxt[FLAG_S] = new_s;
    end else if (dec_swap) begin
      // Flags stay exactly as loaded
      result_nxt = swapped;
      write_reg_nxt = 1'b1;
    end else if (dec_tstore) begin
      status_nxt[FLAG_T] = reg_in[bit_sel];
    end else if (dec_tload) begin
      // Writes back, flags untouched
      result_nxt = bit_loaded;
      write_reg_nxt = 1'b1;
    end else begin
      // Control ops and the no-op leave both masks at zero
      status_nxt = (status_eff & ~flag_clr) | flag_set;
    end
  end

  // Status register; holds until an op or a load changes it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Result and write strobe; every op answers one clock later
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_r <= DATA_RESET;
      result_we_r <= 1'b0;
    end else begin
      result_r <= result_nxt;
      result_we_r <= write_reg_nxt;
    end
  end

  // Control requests for power, watchdog and debug logic; flags are left alone
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_req_r <= 1'b0;
      watchdog_restart_r <= 1'b0;
      debug_break_r <= 1'b0;
    end else begin
      sleep_req_r <= dec_sleep;
      watchdog_restart_r <= dec_wdog;
      debug_break_r <= dec_break;
    end
  end

  // Status leaves straight from its flop
  assign status_flags = status_r;
endmodule

// file: pkg/srfu_pkg.sv
// Package for the shift, rotate and flag datapath slice
package srfu_pkg;
  // Status flag bit positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Every operation here completes in one clock
  localparam int unsigned OP_CYCLES = 1;

  typedef enum logic [4:0] {
    idle_cycle_op = 5'h00,
    logical_shift_right_op = 5'h01,
    rotate_left_carry_op = 5'h02,
    rotate_right_carry_op = 5'h03,
    arith_shift_right_op = 5'h04,
    nibble_swap_op = 5'h05,
    bit_to_transfer_op = 5'h06,
    transfer_to_bit_op = 5'h07,
    status_bit_set_op = 5'h08,
    status_bit_clear_op = 5'h09,
    overflow_set_op = 5'h0a,
    overflow_clear_op = 5'h0b,
    half_carry_set_op = 5'h0c,
    half_carry_clear_op = 5'h0d,
    signed_flag_set_op = 5'h0e,
    signed_flag_clear_op = 5'h0f,
    zero_flag_set_op = 5'h10,
    zero_flag_clear_op = 5'h11,
    carry_set_op = 5'h12,
    carry_clear_op = 5'h13,
    negative_set_op = 5'h14,
    negative_clear_op = 5'h15,
    irq_global_enable_op = 5'h16,
    irq_global_disable_op = 5'h17,
    transfer_flag_set_op = 5'h18,
    transfer_flag_clear_op = 5'h19,
    sleep_op = 5'h1a,
    watchdog_restart_op = 5'h1b,
    debug_break_op = 5'h1c
  } srfu_op_type;
endpackage

// file: test/srfu_unit_sva.sv
// Assertions for the shift and flag slice
`timescale 1ns/100ps
module srfu_unit_sva
  import srfu_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic op_valid,
  input wire logic status_load,
  input wire logic result_we_r,
  input wire srfu_pkg::srfu_op_type op_code,
  input wire logic [7:0] reg_in,
  input wire logic [7:0] status_flags_in,
  input wire logic [7:0] result_r,
  input wire logic [7:0] status_flags,
  input wire logic [2:0] bit_sel,
  input wire logic sleep_req_r,
  input wire logic watchdog_restart_r,
  input wire logic debug_break_r
);
  // Flags an op acts on, after any load in the same cycle
  wire logic [7:0] st = status_load ? status_flags_in : status_flags;
  wire logic [4:0] op = op_valid ? op_code : 5'h1f;
  wire logic [7:0] bs = {st[7], reg_in[bit_sel], st[5:0]};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_lshift_result: assert property (op == logical_shift_right_op |=>
    result_r == $past(reg_in) >> 1 && result_we_r) else $error("logical shift bad");
  a_rotl_carry: assert property (op == rotate_left_carry_op |=>
    result_r[0] == $past(st[0]) && status_flags[0] == $past(reg_in[7])) else $error("rotl bad");
  a_rotr_carry: assert property (op == rotate_right_carry_op |=>
    result_r[7] == $past(st[0]) && status_flags[0] == $past(reg_in[0])) else $error("rotr bad");
  a_ashift_sign: assert property (op == arith_shift_right_op |=>
    result_r[7:6] == {2{$past(reg_in[7])}}) else $error("arith shift bad");
  a_swap_keep: assert property (op == nibble_swap_op |=> status_flags == $past(st))
    else $error("swap bad");
  a_tstore_copy: assert property (op == bit_to_transfer_op |=> status_flags == $past(bs))
    else $error("bit store bad");
  a_tload_bit: assert property (op == transfer_to_bit_op |=>
    result_r[$past(bit_sel)] == $past(st[6]) && status_flags == $past(st)) else $error("bit load bad");
  a_ovf_set: assert property (op == overflow_set_op |=>
    status_flags == ($past(st) | 8'h08)) else $error("ovf bad");
  a_ctl_keep: assert property (op inside {[sleep_op:debug_break_op]} |=>
    status_flags == $past(st)) else $error("ctl bad");
  a_slp_pulse: assert property (op == sleep_op |=> sleep_req_r) else $error("slp bad");
  c_rotl: cover property (op == rotate_left_carry_op);
  c_tstore: cover property (op == bit_to_transfer_op);
  c_tload: cover property (op == transfer_to_bit_op);
  c_slp: cover property (sleep_req_r);
endmodule
bind srfu_unit srfu_unit_sva chk_u (.core_clk, .arst_n, .op_valid, .op_code, .reg_in, .bit_sel,
  .status_flags_in, .status_load, .result_r, .result_we_r, .status_flags, .sleep_req_r,
  .watchdog_restart_r, .debug_break_r);

// file: test/srfu_regfile_model.sv
// Register file model: supplies the operand, takes write-back
`timescale 1ns/100ps
module srfu_regfile_model (
  input wire logic core_clk,
  input wire logic result_we_r,
  input wire logic [7:0] result_r,
  input wire logic preload_en,
  input wire logic [7:0] preload_val,
  output logic [7:0] reg_in
);
  logic [7:0] stored_r = 8'h00;
  // A preload stands for the decoder picking a fresh register
  assign reg_in = preload_en ? preload_val : stored_r;
  // Only the strobe writes back
  always @(posedge core_clk) if (result_we_r) stored_r <= result_r;
endmodule

// file: test/test_srfu_unit.sv
// Self-checking bench for the shift and flag slice
`timescale 1ns/100ps
module test_srfu_unit;
  import srfu_pkg::*;
  logic core_clk = 0, arst_n = 0, op_valid = 0, status_load = 0;
  logic result_we_r, sleep_req_r, watchdog_restart_r, debug_break_r;
  srfu_op_type op_code = idle_cycle_op;
  logic [7:0] reg_in, status_flags_in = 8'h00, result_r, status_flags;
  logic [2:0] bit_sel = 3'h0;
  int bad_count = 0, num_checks = 0;
  logic rf_load = 0;
  logic [7:0] rf_val = 8'h00;
  srfu_regfile_model rf_u (.core_clk, .result_we_r, .result_r, .preload_en(rf_load),
    .preload_val(rf_val), .reg_in);
  srfu_unit dut_u (.core_clk, .arst_n, .op_valid, .op_code, .reg_in, .bit_sel,
    .status_flags_in, .status_load, .result_r, .result_we_r, .status_flags, .sleep_req_r,
    .watchdog_restart_r, .debug_break_r);
  initial forever #5 core_clk = ~core_clk;
  task chk(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task test_done;
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One op per edge; valid stays high so ops run back to back
  task run(srfu_op_type c, logic [7:0] v, logic [2:0] b, logic [7:0] s, logic l);
    rf_load = l;
    rf_val = v;
    op_valid = 1'b1;
    op_code = c;
    bit_sel = b;
    status_flags_in = s;
    status_load = l;
    @(posedge core_clk);
    #1;
  endtask
  task t_shift(srfu_op_type c, logic [7:0] v, logic ci);
    logic [7:0] r;
    logic co;
    case (c)
      logical_shift_right_op: {r, co} = {1'b0, v};
      rotate_left_carry_op: {co, r} = {v, ci};
      rotate_right_carry_op: {r, co} = {ci, v};
      default: {r, co} = {v[7], v};
    endcase
    run(c, v, 3'h0, {7'h50, ci}, 1'b1);
    chk("res", r, result_r);
    chk("flags", {3'h5, co, r[7] ^ co, r[7], r == 8'h00, co}, status_flags);
    chk("we", 8'h01, {7'h00, result_we_r});
  endtask
  // Each dedicated flag op pair, then the indexed form
  task t_flags;
    int k[8] = '{FLAG_V, FLAG_H, FLAG_S, FLAG_Z, FLAG_C, FLAG_N, FLAG_I, FLAG_T};
    for (int i = 0; i < 8; i++) begin
      run(srfu_op_type'(5'h0a + 2 * i), 8'h00, 3'h0, 8'h00, 1'b1);
      chk("set", 8'h01 << k[i], status_flags);
      chk("we", 8'h00, {7'h00, result_we_r});
      run(srfu_op_type'(5'h0b + 2 * i), 8'h00, 3'h0, 8'hff, 1'b1);
      chk("clear", ~(8'h01 << k[i]), status_flags);
      run(status_bit_clear_op, 8'h00, 3'(i), 8'hff, 1'b1);
      chk("idx", ~(8'h01 << i), status_flags);
      run(status_bit_set_op, 8'h00, 3'(i), 8'h00, 1'b1);
      chk("idxs", 8'h01 << i, status_flags);
    end
  endtask
  task t_ctl;
    logic [7:0] p;
    for (int i = 0; i < 4; i++) begin
      run(srfu_op_type'(5'h1a + i), 8'h00, 3'h0, 8'ha5, 1'b1);
      chk("ctl", 8'ha5, status_flags);
      p = {5'h00, sleep_req_r, watchdog_restart_r, debug_break_r};
      chk("pulse", 8'h04 >> i, p);
    end
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    #1 arst_n = 1;
    chk("rst", 8'h00, status_flags);
    t_shift(logical_shift_right_op, 8'h01, 1'b0);
    t_shift(rotate_left_carry_op, 8'h80, 1'b0);
    run(idle_cycle_op, 8'h00, 3'h0, 8'h00, 1'b0);
    run(rotate_right_carry_op, 8'h00, 3'h0, 8'h00, 1'b0);
    chk("chain", 8'h80, result_r);
    chk("chainf", 8'hac, status_flags);
    t_shift(rotate_right_carry_op, 8'h01, 1'b1);
    t_shift(arith_shift_right_op, 8'h81, 1'b0);
    run(nibble_swap_op, 8'h3c, 3'h0, 8'hff, 1'b1);
    chk("swap", 8'hc3, result_r);
    run(bit_to_transfer_op, 8'hef, 3'h4, 8'hff, 1'b1);
    chk("tstore", 8'hbf, status_flags);
    run(transfer_to_bit_op, 8'h00, 3'h7, 8'h40, 1'b1);
    chk("tload", 8'h80, result_r);
    chk("tloadf", 8'h40, status_flags);
    t_flags;
    t_ctl;
    test_done;
  end
  // Watchdog well past the roughly 60 cycles the run needs
  initial begin
    #8000;
    bad_count++;
    test_done;
  end
endmodule
